// ---- hdl/timer_unit_pkg.sv ----
package timer_unit_pkg;

   // timer slots: first group 0..2, second group 3..4
   localparam int N_TMR  = 5;
   localparam int AUX_A  = 0;
   localparam int CORE   = 1;
   localparam int AUX_B  = 2;
   localparam int CAPB   = 3;
   localparam int FINE   = 4;
   localparam int TMR_W  = 16;
   localparam int ADDR_W = 7;

   // byte offsets on the register bus
   localparam logic [6:0] CTRL_OFF   = 7'h00;
   localparam logic [6:0] VAL_OFF    = 7'h20;
   localparam logic [6:0] CAPTURE_RELOAD_REG_OFF = 7'h40;
   localparam logic [6:0] STATUS_OFF = 7'h44;

   // finest resolution in system clock cycles, and its log2
   localparam int         G1_RES_CYC = 4;
   localparam int         G2_RES_CYC = 2;
   localparam logic [3:0] G1_BASE_SH = 4'($clog2(G1_RES_CYC));
   localparam logic [3:0] G2_BASE_SH = 4'($clog2(G2_RES_CYC));

   localparam logic [15:0] CTRL_RST   = 16'h0000;
   localparam logic [15:0] VAL_RST    = 16'h0000;
   localparam logic [15:0] CAPTURE_RELOAD_REG_RST = 16'h0000;

   // auxiliary timer role
   localparam logic [1:0] ROLE_NORMAL = 2'h0;
   localparam logic [1:0] ROLE_CAP    = 2'h1;
   localparam logic [1:0] ROLE_REL    = 2'h2;

   // status layout: bits 4..0 wrap flags, then these
   localparam int ST_CAP_BIT  = 5;
   localparam int ST_CORE_TL  = 6;
   localparam int ST_FINE_TL  = 7;

   typedef enum logic [1:0] {
      MODE_TIMER   = 2'b00,
      MODE_GATED   = 2'b01,
      MODE_COUNTER = 2'b10,
      MODE_INCR    = 2'b11
   } tmr_mode_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;

   // per timer control word, bit 15 down to bit 0
   typedef struct packed {
      logic       latch_clk;
      logic [1:0] trig;
      logic [1:0] role;
      logic [1:0] edge_s;
      logic       dir_ext;
      logic       dir_sw;
      logic       run;
      logic       gate_lvl;
      tmr_mode_t  mode;
      logic [2:0] presc;
   } tmr_ctrl_t;

endpackage

// ---- hdl/count_cell.sv ----
`timescale 1ns/1ps
module count_cell #(
   parameter int W = 16
) (
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   input  wire logic         cnt_in,
   input  wire logic         down_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] load_val_in,
   output logic      [W-1:0] value_out,
   output logic              wrap_out
);
   logic [W-1:0] val_ff;
   logic [W-1:0] nxt_val;

   // wrap is reported from the count alone so a same-cycle reload cannot loop back
   assign wrap_out  = cnt_in & (down_in ? (val_ff == '0) : (&val_ff));
   assign nxt_val   = load_in ? load_val_in :
                      cnt_in  ? (down_in ? val_ff - 1'b1 : val_ff + 1'b1) : val_ff;
   assign value_out = val_ff;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         val_ff <= W'(timer_unit_pkg::VAL_RST);
      end else begin
         val_ff <= nxt_val;
      end
   end
endmodule // count_cell

// ---- hdl/dual_group_timer.sv ----
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - five 16-bit timers, groups of three and two
// - timers chain only within their own group
// - first group: timer, gated, counter, incremental modes
// - timer mode counts prescaled system clock
// - counter mode counts edges on input pin
// - gated mode counts while pin at gate level
// - first group resolution four system clocks
// - direction by software or external direction pin
// - incremental mode decodes quadrature input and direction
// - core toggle latch flips on wrap, drives pin
// - core toggle latch can clock auxiliary timers
// - auxiliary as capture/reload register stops counting
// - capture copies core value on input edge
// - reload loads core on pin or latch edge
// - opposite-edge reloads give continuous pwm output
// - second group resolution two system clocks
// - second group: prescaled clock or external signals
// - second group direction software or direction pin
// - fine toggle latch clocks base timer, drives pin
// - fine wrap reloads from capture register, clocks compare
// - capture register latches base timer, optional clear
// - capture also from core input/direction pin edges
module dual_group_timer #(
   parameter int PRE_W = 10
) (
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic [6:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   input  wire logic [3:0]  byteenable_in,
   output logic      [31:0] readdata_out,
   output logic             waitrequest_out,
   input  wire logic [4:0]  timer_input_pin_in,
   input  wire logic [4:0]  direction_pin_in,
   input  wire logic        capture_trigger_pin_in,
   output logic             core_toggle_out,
   output logic             fine_toggle_out,
   output logic             ext_compare_clk_out
);
   localparam int N = timer_unit_pkg::N_TMR;
   localparam int C = timer_unit_pkg::CORE;
   localparam int F = timer_unit_pkg::FINE;
   localparam int B = timer_unit_pkg::CAPB;

   function automatic logic edge_sel(input logic [1:0] sel, input logic now, input logic old);
      return (sel[0] & now & ~old) | (sel[1] & ~now & old);
   endfunction

   function automatic logic pre_tick(input logic [PRE_W-1:0] pre, input logic [3:0] sh);
      logic [PRE_W-1:0] m;
      m = PRE_W'((32'h1 << sh) - 32'h1);
      return (pre & m) == m;
   endfunction

   function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic rel_trig(input timer_unit_pkg::tmr_ctrl_t c, input logic pin_ev,
                                     input logic rise, input logic fall);
      return (c.role == timer_unit_pkg::ROLE_REL) &&
             ((c.trig == 2'h0) ? pin_ev : ((c.trig[0] & rise) | (c.trig[1] & fall)));
   endfunction

   // pin synchronisers; prev_ff keeps the last synchronised sample for edges
   logic [10:0] sync1_ff;
   logic [10:0] sync2_ff;
   logic [10:0] prev_ff;
   logic [4:0]  tin;
   logic [4:0]  tin_p;
   logic [4:0]  dpin;
   logic [4:0]  dpin_p;
   logic        cpin;
   logic        cpin_p;

   assign tin    = sync2_ff[4:0];
   assign tin_p  = prev_ff[4:0];
   assign dpin   = sync2_ff[9:5];
   assign dpin_p = prev_ff[9:5];
   assign cpin   = sync2_ff[10];
   assign cpin_p = prev_ff[10];

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sync1_ff <= 11'h000;
         sync2_ff <= 11'h000;
         prev_ff  <= 11'h000;
      end else begin
         sync1_ff <= {capture_trigger_pin_in, direction_pin_in, timer_input_pin_in};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // register bus slave
   timer_unit_pkg::bus_state_t state_ff;
   timer_unit_pkg::bus_state_t nxt_state;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] rd_mux;
   logic        wr_fire;
   logic [4:0]  widx;
   logic [2:0]  tsel;
   logic        ctrl_hit;
   logic        val_hit;
   logic        capture_reload_reg_hit;
   logic        status_hit;

   always_comb begin
      case (state_ff)
         timer_unit_pkg::BUS_IDLE: begin
            nxt_state = (read_in | write_in) ? timer_unit_pkg::BUS_ACK : timer_unit_pkg::BUS_IDLE;
         end
         timer_unit_pkg::BUS_ACK: begin
            nxt_state = timer_unit_pkg::BUS_IDLE;
         end
         default: begin
            nxt_state = timer_unit_pkg::BUS_IDLE;
         end
      endcase
   end

   assign widx       = address_in[6:2];
   // ctrl and value blocks sit on 32-byte boundaries, so the low index bits pick the timer
   assign tsel       = widx[2:0];
   assign ctrl_hit   = (widx >= timer_unit_pkg::CTRL_OFF[6:2]) &&
                       (widx < timer_unit_pkg::CTRL_OFF[6:2] + 5'(N));
   assign val_hit    = (widx >= timer_unit_pkg::VAL_OFF[6:2]) &&
                       (widx < timer_unit_pkg::VAL_OFF[6:2] + 5'(N));
   assign capture_reload_reg_hit = widx == timer_unit_pkg::CAPTURE_RELOAD_REG_OFF[6:2];
   assign status_hit = widx == timer_unit_pkg::STATUS_OFF[6:2];
   assign wr_fire    = write_in && (state_ff == timer_unit_pkg::BUS_ACK);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_ff <= timer_unit_pkg::BUS_IDLE;
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         wait_ff  <= nxt_state != timer_unit_pkg::BUS_ACK;
         if (read_in && state_ff == timer_unit_pkg::BUS_IDLE) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   assign readdata_out    = rdata_ff;
   assign waitrequest_out = wait_ff;

   // timers
   timer_unit_pkg::tmr_ctrl_t ctrl_ff [N];
   logic [15:0] tval [N];
   logic [15:0] hw_val [N];
   logic [N-1:0] hw_load;
   logic [N-1:0] wrap;
   logic [N-1:0] cnt_en;
   logic [N-1:0] pin_ev_w;
   logic [N-1:0] sw_val_wr;
   logic [PRE_W-1:0] pre_ff;
   logic        core_tl_ff;
   logic        fine_tl_ff;
   logic        nxt_core_tl;
   logic        nxt_fine_tl;
   logic [15:0] capture_reload_reg_ff;
   logic [5:0]  flags_ff;
   logic [5:0]  flag_clr;
   logic [7:0]  status;
   logic        core_out_ff;
   logic        fine_out_ff;
   logic        cmp_clk_ff;

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_tmr
         localparam bit G1     = gi < 3;
         localparam bit IS_AUX = (gi == timer_unit_pkg::AUX_A) || (gi == timer_unit_pkg::AUX_B);
         localparam bit LATCH  = IS_AUX || (gi == B);
         timer_unit_pkg::tmr_ctrl_t c;
         logic tick;
         logic a_ev;
         logic b_ev;
         logic quad_cnt;
         logic quad_down;
         logic incr;
         logic raw;
         logic down;
         logic busy;
         logic ctrl_wr;

         assign c        = ctrl_ff[gi];
         assign tick     = pre_tick(pre_ff, 4'(c.presc) +
                           (G1 ? timer_unit_pkg::G1_BASE_SH : timer_unit_pkg::G2_BASE_SH));
         assign pin_ev_w[gi] = edge_sel(c.edge_s, tin[gi], tin_p[gi]);
         assign a_ev     = tin[gi] ^ tin_p[gi];
         assign b_ev     = dpin[gi] ^ dpin_p[gi];
         assign quad_cnt = (a_ev & c.edge_s[0]) | (b_ev & c.edge_s[1]);
         assign quad_down = (a_ev & c.edge_s[0]) ? (tin[gi] == dpin[gi])
                                                 : (tin[gi] != dpin[gi]);
         assign incr     = G1 && (c.mode == timer_unit_pkg::MODE_INCR);
         // latch clocking: auxiliaries follow the core latch, base timer the fine latch
         assign raw = (LATCH && c.latch_clk) ? wrap[gi == B ? F : C] :
                      (c.mode == timer_unit_pkg::MODE_TIMER) ? tick :
                      (c.mode == timer_unit_pkg::MODE_GATED) ?
                         tick & (tin[gi] == c.gate_lvl) :
                      incr ? quad_cnt : pin_ev_w[gi];
         assign busy       = IS_AUX && (c.role != timer_unit_pkg::ROLE_NORMAL);
         assign cnt_en[gi] = c.run & ~busy & raw;
         assign down       = incr ? quad_down : c.dir_sw ^ (c.dir_ext & dpin[gi]);
         assign ctrl_wr    = wr_fire && ctrl_hit && (tsel == 3'(gi));
         assign sw_val_wr[gi] = wr_fire && val_hit && (tsel == 3'(gi));

         always_ff @(posedge sys_clk_in) begin
            if (rst_in) begin
               ctrl_ff[gi] <= timer_unit_pkg::CTRL_RST;
            end else if (ctrl_wr) begin
               ctrl_ff[gi] <= be_merge(ctrl_ff[gi], writedata_in, byteenable_in);
            end
         end

         count_cell #(.W(timer_unit_pkg::TMR_W)) u_cell (
            .sys_clk_in  (sys_clk_in),
            .rst_in      (rst_in),
            .cnt_in      (cnt_en[gi]),
            .down_in     (down),
            .load_in     (sw_val_wr[gi] | hw_load[gi]),
            .load_val_in (sw_val_wr[gi] ? be_merge(tval[gi], writedata_in, byteenable_in)
                                        : hw_val[gi]),
            .value_out   (tval[gi]),
            .wrap_out    (wrap[gi])
         );
      end
   endgenerate

   // hardware loads between timers of one group
   logic cap_a;
   logic cap_b;
   logic rel_a;
   logic rel_b;
   logic tl_rise;
   logic tl_fall;
   logic cap5;
   timer_unit_pkg::tmr_ctrl_t c5;

   assign tl_rise = wrap[C] & ~core_tl_ff;
   assign tl_fall = wrap[C] & core_tl_ff;
   assign cap_a = (ctrl_ff[timer_unit_pkg::AUX_A].role == timer_unit_pkg::ROLE_CAP) &&
                  pin_ev_w[timer_unit_pkg::AUX_A];
   assign cap_b = (ctrl_ff[timer_unit_pkg::AUX_B].role == timer_unit_pkg::ROLE_CAP) &&
                  pin_ev_w[timer_unit_pkg::AUX_B];
   assign rel_a = rel_trig(ctrl_ff[timer_unit_pkg::AUX_A], pin_ev_w[timer_unit_pkg::AUX_A],
                           tl_rise, tl_fall);
   assign rel_b = rel_trig(ctrl_ff[timer_unit_pkg::AUX_B], pin_ev_w[timer_unit_pkg::AUX_B],
                           tl_rise, tl_fall);
   assign c5    = ctrl_ff[B];
   assign cap5  = (c5.trig == 2'h0) ? edge_sel(c5.edge_s, cpin, cpin_p) :
                  (c5.trig[0] & edge_sel(c5.edge_s, tin[C], tin_p[C])) |
                  (c5.trig[1] & edge_sel(c5.edge_s, dpin[C], dpin_p[C]));

   assign hw_load[timer_unit_pkg::AUX_A] = cap_a;
   assign hw_val[timer_unit_pkg::AUX_A]  = tval[C];
   assign hw_load[C]                     = rel_a | rel_b;
   assign hw_val[C]                      = rel_a ? tval[timer_unit_pkg::AUX_A]
                                                 : tval[timer_unit_pkg::AUX_B];
   assign hw_load[timer_unit_pkg::AUX_B] = cap_b;
   assign hw_val[timer_unit_pkg::AUX_B]  = tval[C];
   assign hw_load[B]                     = cap5 & c5.role[0];
   assign hw_val[B]                      = 16'h0000;
   assign hw_load[F]                     = wrap[F] & ctrl_ff[F].role[0];
   assign hw_val[F]                      = capture_reload_reg_ff;

   assign nxt_core_tl = core_tl_ff ^ wrap[C];
   assign nxt_fine_tl = fine_tl_ff ^ wrap[F];
   assign flag_clr    = (wr_fire && status_hit && byteenable_in[0]) ? writedata_in[5:0] : 6'h00;
   assign status      = {fine_tl_ff, core_tl_ff, flags_ff};
   assign rd_mux      = ctrl_hit   ? {16'h0000, ctrl_ff[tsel]} :
                        val_hit    ? {16'h0000, tval[tsel]} :
                        capture_reload_reg_hit ? {16'h0000, capture_reload_reg_ff} :
                        status_hit ? {24'h000000, status} : 32'h0000_0000;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pre_ff      <= '0;
         core_tl_ff  <= 1'b0;
         fine_tl_ff  <= 1'b0;
         capture_reload_reg_ff   <= timer_unit_pkg::CAPTURE_RELOAD_REG_RST;
         flags_ff    <= 6'h00;
         core_out_ff <= 1'b0;
         fine_out_ff <= 1'b0;
         cmp_clk_ff  <= 1'b0;
      end else begin
         pre_ff      <= pre_ff + 1'b1;
         core_tl_ff  <= nxt_core_tl;
         fine_tl_ff  <= nxt_fine_tl;
         if (cap5) begin
            capture_reload_reg_ff <= tval[B];
         end else if (wr_fire && capture_reload_reg_hit) begin
            capture_reload_reg_ff <= be_merge(capture_reload_reg_ff, writedata_in, byteenable_in);
         end
         flags_ff    <= (flags_ff & ~flag_clr) | {cap5, wrap};
         core_out_ff <= ctrl_ff[C].role[1] & nxt_core_tl;
         fine_out_ff <= ctrl_ff[F].role[1] & nxt_fine_tl;
         cmp_clk_ff  <= wrap[F];
      end
   end

   assign core_toggle_out     = core_out_ff;
   assign fine_toggle_out     = fine_out_ff;
   assign ext_compare_clk_out = cmp_clk_ff;

   logic busy_aux_a;
   assign busy_aux_a = ctrl_ff[0].role != timer_unit_pkg::ROLE_NORMAL;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   core_latch_a: assert property (wrap[C] |=> core_tl_ff != $past(core_tl_ff))
      else $error("core latch did not flip on wrap");
   core_hold_a: assert property (!wrap[C] |=> $stable(core_tl_ff))
      else $error("core latch moved without wrap");
   aux_stop_a: assert property (
      (busy_aux_a && !hw_load[0] && !sw_val_wr[0]) |=> $stable(tval[0]))
      else $error("aux timer counted while used as register");
   aux_cap_a: assert property ((cap_a && !sw_val_wr[0]) |=> tval[0] == $past(tval[C]))
      else $error("capture did not copy core value");
   core_rel_a: assert property (
      (rel_b && !rel_a && !sw_val_wr[C]) |=> tval[C] == $past(tval[2]))
      else $error("reload did not load core value");
   g1_res_a: assert property (
      (cnt_en[C] && ctrl_ff[C].mode == timer_unit_pkg::MODE_TIMER && !ctrl_ff[C].latch_clk)
      |-> pre_ff[1:0] == 2'h3)
      else $error("first group counted faster than four cycles");
   g2_res_a: assert property (
      (cnt_en[F] && ctrl_ff[F].mode == timer_unit_pkg::MODE_TIMER) |-> pre_ff[0] == 1'b1)
      else $error("second group counted faster than two cycles");
   capture_reload_reg_cap_a: assert property (cap5 |=> capture_reload_reg_ff == $past(tval[B]))
      else $error("capture register missed base timer value");
   fine_rel_a: assert property (
      (hw_load[F] && !sw_val_wr[F]) |=> tval[F] == $past(capture_reload_reg_ff))
      else $error("fine timer reload from capture register failed");
   cmp_clk_a: assert property (wrap[F] |=> ext_compare_clk_out)
      else $error("compare clock pulse missing");
   flag_set_a: assert property (cap5 |=> flags_ff[timer_unit_pkg::ST_CAP_BIT])
      else $error("capture flag not set");
   bus_ack_a: assert property (((read_in || write_in) && wait_ff) |=> !waitrequest_out ##1 wait_ff)
      else $error("bus answer not within one cycle");

   pwm_cov_c: cover property (rel_a ##[1:1000] rel_b);
   cap_cov_c: cover property (cap5 && c5.role[0]);
   quad_cov_c: cover property (cnt_en[C] && ctrl_ff[C].mode == timer_unit_pkg::MODE_INCR);
   read_cov_c: cover property (read_in && !waitrequest_out);
endmodule // dual_group_timer

// ---- verification/pin_source_model.sv ----
`timescale 1ns/1ps
module pin_source_model (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic [9:0] toggle_in,
   input  wire logic       quad_up_in,
   input  wire logic       quad_dn_in,
   input  wire logic       cap_toggle_in,
   output logic      [4:0] timer_input_pin_out,
   output logic      [4:0] direction_pin_out,
   output logic            capture_trigger_pin_out
);
   logic quad_eq;
   logic quad_a;
   logic quad_b;

   // gray-code stepping of the sensor pair on the core timer's pins
   assign quad_eq = timer_input_pin_out[1] == direction_pin_out[1];
   assign quad_a  = (quad_up_in & quad_eq) | (quad_dn_in & ~quad_eq);
   assign quad_b  = (quad_up_in & ~quad_eq) | (quad_dn_in & quad_eq);

   // each level stands until the next request; callers space requests by 8 clocks
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         timer_input_pin_out     <= 5'h00;
         direction_pin_out       <= 5'h00;
         capture_trigger_pin_out <= 1'b0;
      end else begin
         timer_input_pin_out     <= timer_input_pin_out ^ toggle_in[4:0] ^ {3'h0, quad_a, 1'h0};
         direction_pin_out       <= direction_pin_out ^ toggle_in[9:5] ^ {3'h0, quad_b, 1'h0};
         capture_trigger_pin_out <= capture_trigger_pin_out ^ cap_toggle_in;
      end
   end
endmodule // pin_source_model

// ---- verification/dual_group_timer_test.sv ----
`timescale 1ns/1ps
module dual_group_timer_test;
   logic        sys_clk;
   logic        rst;
   logic [6:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [4:0]  tmr_pins;
   logic [4:0]  dir_pins;
   logic        cap_pin;
   logic        core_out;
   logic        fine_out;
   logic        cmp_clk;
   logic [12:0] req;
   logic [31:0] rdata;
   logic        sel_cmp;
   logic        probe;
   logic        lat;
   int          mismatches;
   int          check_count;
   int          n;
   int          cyc = 0;

   assign probe = sel_cmp ? cmp_clk : core_out;

   dual_group_timer #(.PRE_W(10)) i_dual_group_timer (
      .sys_clk_in(sys_clk), .rst_in(rst), .address_in(address), .read_in(read),
      .write_in(write), .writedata_in(writedata), .byteenable_in(byteenable),
      .readdata_out(readdata), .waitrequest_out(waitrequest), .timer_input_pin_in(tmr_pins),
      .direction_pin_in(dir_pins), .capture_trigger_pin_in(cap_pin),
      .core_toggle_out(core_out), .fine_toggle_out(fine_out), .ext_compare_clk_out(cmp_clk));

   pin_source_model i_pin_source_model (
      .sys_clk_in(sys_clk), .rst_in(rst), .toggle_in(req[9:0]), .quad_up_in(req[10]),
      .quad_dn_in(req[11]), .cap_toggle_in(req[12]), .timer_input_pin_out(tmr_pins),
      .direction_pin_out(dir_pins), .capture_trigger_pin_out(cap_pin));

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [6:0] ctl(input int t);
      return timer_unit_pkg::CTRL_OFF + 7'(4 * t);
   endfunction

   function automatic logic [6:0] val(input int t);
      return timer_unit_pkg::VAL_OFF + 7'(4 * t);
   endfunction

   task automatic bus(input logic wr_en, input logic [6:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      @(posedge sys_clk);
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      write      <= wr_en;
      read       <= ~wr_en;
      // hold the request until waitrequest is sampled low; a hang ends at the bench timeout
      do begin
         @(posedge sys_clk);
      end while (waitrequest !== 1'b0);
      rdata = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task automatic rd(input logic [6:0] a);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask

   // two value reads whose capture edges lie 64 clocks apart
   task automatic slope(input int t, input logic [15:0] d);
      logic [15:0] v0;
      rd(val(t));
      v0 = rdata[15:0];
      repeat (61) @(posedge sys_clk);
      rd(val(t));
      check({16'h0, rdata[15:0] - v0}, {16'h0, d});
   endtask

   task automatic tgl(input logic [12:0] m);
      @(posedge sys_clk);
      req <= m;
      @(posedge sys_clk);
      req <= 13'h0;
      repeat (6) @(posedge sys_clk);
   endtask

   // length in clocks of the current run of lvl on the probe
   task automatic span(input logic lvl);
      n = 0;
      while (probe === lvl && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   initial begin
      rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 7'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      req = 13'h0;
      sel_cmp = 1'b0;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(ctl(i));
         check(rdata, 32'h0);
         rd(val(i));
         check(rdata, 32'h0);
      end
      wr(7'h48, 32'hffff);
      rd(7'h48);
      check(rdata, 32'h0);
      bus(1'b1, ctl(0), 32'hffff, 4'h1);
      rd(ctl(0));
      check(rdata, 32'h00ff);
      wr(ctl(0), 32'h0);
      wr(ctl(1), 32'h0040);
      slope(1, 16'd16);
      wr(ctl(1), 32'h0041);
      slope(1, 16'd8);
      wr(ctl(1), 32'h00c0);
      slope(1, 16'hfff0);
      wr(ctl(1), 32'h0140);
      tgl(13'h040);
      slope(1, 16'hfff0);
      wr(ctl(4), 32'h0040);
      slope(4, 16'd32);
      wr(ctl(4), 32'h0140);
      tgl(13'h200);
      slope(4, 16'hffe0);
      wr(ctl(4), 32'h0);
      wr(ctl(0), 32'h0068);
      slope(0, 16'h0);
      tgl(13'h001);
      slope(0, 16'd16);
      wr(ctl(0), 32'h0);
      wr(ctl(1), 32'h0);
      tgl(13'h040);
      wr(val(1), 32'h0);
      wr(ctl(1), 32'h0650);
      repeat (3) tgl(13'h002);
      rd(val(1));
      check(rdata, 32'h3);
      wr(ctl(1), 32'h0250);
      repeat (4) tgl(13'h002);
      rd(val(1));
      check(rdata, 32'h5);
      wr(val(1), 32'h0);
      wr(ctl(1), 32'h0658);
      repeat (5) tgl(13'h400);
      repeat (2) tgl(13'h800);
      rd(val(1));
      check(rdata, 32'h3);
      wr(ctl(1), 32'h0);
      wr(val(1), 32'h1234);
      wr(ctl(2), 32'h0e40);
      tgl(13'h004);
      rd(val(2));
      check(rdata, 32'h1234);
      slope(2, 16'h0);
      wr(val(1), 32'hfffe);
      wr(7'h44, 32'h3f);
      rd(7'h44);
      lat = rdata[6];
      wr(val(0), 32'h0);
      wr(ctl(0), 32'h8040);
      wr(ctl(1), 32'h1040);
      repeat (16) @(posedge sys_clk);
      check({31'h0, core_out}, {31'h0, ~lat});
      rd(val(0));
      check(rdata, 32'h1);
      wr(ctl(0), 32'h0);
      rd(7'h44);
      check(rdata & 32'h42, {25'h0, ~lat, 6'h02});
      wr(7'h44, 32'h02);
      rd(7'h44);
      check(rdata & 32'h02, 32'h0);
      wr(val(0), 32'hfffd);
      wr(val(2), 32'hfffb);
      wr(ctl(0), 32'h3000);
      wr(ctl(2), 32'h5000);
      wr(val(1), 32'hfffe);
      span(1'b0);
      span(1'b1);
      span(1'b0);
      check(32'(n), 32'd20);
      span(1'b1);
      check(32'(n), 32'd12);
      wr(ctl(1), 32'h0);
      wr(ctl(0), 32'h0);
      wr(ctl(2), 32'h0);
      wr(7'h40, 32'hfff8);
      wr(val(4), 32'hfff8);
      wr(ctl(4), 32'h1840);
      sel_cmp = 1'b1;
      span(1'b0);
      span(1'b1);
      check(32'(n), 32'd1);
      span(1'b0);
      check(32'(n), 32'd15);
      lat = fine_out;
      repeat (16) @(posedge sys_clk);
      check({31'h0, fine_out}, {31'h0, ~lat});
      wr(ctl(4), 32'h0);
      wr(7'h44, 32'h3f);
      wr(val(3), 32'h0abc);
      wr(ctl(3), 32'h0e00);
      tgl(13'h1000);
      rd(7'h40);
      check(rdata, 32'h0abc);
      rd(val(3));
      check(rdata, 32'h0);
      rd(7'h44);
      check(rdata & 32'h20, 32'h20);
      wr(val(3), 32'h0055);
      wr(ctl(3), 32'h2600);
      tgl(13'h002);
      rd(7'h40);
      check(rdata, 32'h0055);
      wr(val(3), 32'h0066);
      wr(ctl(3), 32'h4600);
      tgl(13'h040);
      rd(7'h40);
      check(rdata, 32'h0066);
      wr(val(3), 32'h0);
      wr(ctl(3), 32'h0650);
      repeat (2) tgl(13'h008);
      rd(val(3));
      check(rdata, 32'h2);
      wrap_up();
   end
endmodule // dual_group_timer_test
